// file: common/sefe_pkg.sv
// Shared constants and types for the serial EEPROM slave front end
package sefe_pkg;
  localparam int ADDR_W    = 11;
  localparam int TYPE_BIT  = 7;
  localparam int CHIP_MSB  = 6;
  localparam int CHIP_LSB  = 4;
  localparam int UPPER_MSB = 3;
  localparam int UPPER_LSB = 1;
  localparam int RW_BIT    = 0;
  localparam int PAGE_W    = 4;
  localparam int PIN_W     = 7;
  localparam int PIN_SCL   = 0;
  localparam int PIN_SDA   = 1;
  localparam int PIN_E0    = 2;
  localparam int PIN_E1N   = 3;
  localparam int PIN_E2    = 4;
  localparam int PIN_WP    = 5;
  localparam int PIN_LOCK  = 6;

  localparam logic [3:0]        BIT_RST       = 4'h0;
  localparam logic [3:0]        BIT_STOP_SLOT = 4'h1;
  localparam logic [3:0]        BIT_PRE       = 4'h7;
  localparam logic [3:0]        BIT_LAST      = 4'h8;
  localparam logic [3:0]        BIT_ACK       = 4'h9;
  localparam logic [ADDR_W-1:0] ADDR_RST      = 11'h000;
  localparam logic [7:0]        BYTE_RST      = 8'h00;
  // Bus idles high and lock-out is assumed active until sampled
  localparam logic [PIN_W-1:0]  PIN_RST       = 7'h43;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_DEVSEL = 3'b001,
    ST_ADDR   = 3'b010,
    ST_WDATA  = 3'b011,
    ST_RDATA  = 3'b100,
    ST_BUSY   = 3'b101
  } sefe_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
    logic              wr_stb;
    logic              prog_start;
  } sefe_mem_req_t;
endpackage : sefe_pkg

// file: verilog/sefe_front_end.sv
// Two-wire serial EEPROM slave front end and its pin synchroniser
//
// Overview of operation
// - Start: SDA falls while SCL high
// - Watch for Start always, except programming or supply lock-out
// - Stop: SDA rises while SCL high
// - Stop ending a write starts programming
// - Read noack then Stop gives standby
// - Release after eight bits, ack on ninth
// - Capture SDA on rising SCL
// - Bit zero: one reads, zero writes
// - Bits b3..b1 are address bits 10..8
// - Bits b6..b4 compared with strap pins
// - Match straps, middle strap inverted
// - Ack on match, else release, standby
// - Write protect refuses data bytes only
// - Floating write protect means writable
// - Supply lock-out disables everything
// - Device is slave, master clocks
// - SDA only pulled low or released
// - Programming keeps SDA off, no answers
// - Programming only on Stop in tenth slot
// - Page write bumps low four bits only
// - Read noack stops output, standby

module sefe_pin_sync
  import sefe_pkg::*;
#(
  parameter int               W   = PIN_W,
  parameter logic [PIN_W-1:0] RST = PIN_RST
)(
  input  wire logic         core_clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] pin_f
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] filt_ff;
  wire  [W-1:0] nxt_filt = (s2_ff & s3_ff) | (filt_ff & (s2_ff | s3_ff));

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_ff   <= RST[W-1:0];
      s2_ff   <= RST[W-1:0];
      s3_ff   <= RST[W-1:0];
      filt_ff <= RST[W-1:0];
    end
    else
    begin
      s1_ff   <= pin_i;
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      filt_ff <= nxt_filt;
    end
  end

  assign pin_f = filt_ff;
endmodule : sefe_pin_sync

module sefe_front_end
#(
  // Arbitrary value
  parameter logic TYPE_ID = 1'h0
)(
  input  wire logic            core_clk,
  input  wire logic            resetn,
  input  wire logic            link_scl_clk,
  input  wire logic            sda_i,
  output logic                 sda_o,
  output logic                 sda_oe,
  input  wire logic            chip_sel_pin0,
  input  wire logic            chip_sel_pin1_inverted,
  input  wire logic            chip_sel_pin2,
  input  wire logic            write_protect_input,
  input  wire logic            supply_lockout_reset,
  input  wire logic [7:0]      rd_data,
  input  wire logic            prog_done,
  output sefe_pkg::sefe_mem_req_t mem_req
);
  import sefe_pkg::*;

  logic [7:0]        link_shift_ff;
  logic [PIN_W-1:0]  pins_raw;
  logic [PIN_W-1:0]  pins_f;
  sefe_state_t       state_ff;
  sefe_state_t       nxt_state;
  logic [3:0]        bit_cnt_ff;
  logic [3:0]        nxt_cnt;
  logic              sda_oe_ff;
  logic              nxt_oe;
  logic [ADDR_W-1:0] addr_ff;
  logic [ADDR_W-1:0] nxt_addr;
  logic [7:0]        tx_ff;
  logic [7:0]        nxt_tx;
  logic              ack_pend_ff;
  logic              nxt_ack;
  logic              tx_active_ff;
  logic              nxt_txa;
  logic              wp_cmd_ff;
  logic              nxt_wp;
  logic              have_data_ff;
  logic              nxt_have;
  logic [7:0]        wr_data_ff;
  logic [7:0]        nxt_wr_data;
  logic              wr_stb_ff;
  logic              nxt_wr_stb;
  logic              prog_ff;
  logic              nxt_prog;
  logic              scl_prev_ff;
  logic              sda_prev_ff;

  // Link side: the master's SCL is the only clock here
  always_ff @(posedge link_scl_clk or negedge resetn)
  begin
    if (!resetn)
      link_shift_ff <= BYTE_RST;
    else
      link_shift_ff <= {link_shift_ff[6:0], sda_i};
  end

  assign pins_raw[PIN_SCL]  = link_scl_clk;
  assign pins_raw[PIN_SDA]  = sda_i;
  assign pins_raw[PIN_E0]   = chip_sel_pin0;
  assign pins_raw[PIN_E1N]  = chip_sel_pin1_inverted;
  assign pins_raw[PIN_E2]   = chip_sel_pin2;
  assign pins_raw[PIN_WP]   = write_protect_input;
  assign pins_raw[PIN_LOCK] = supply_lockout_reset;

  sefe_pin_sync #(
    .W   (PIN_W),
    .RST (PIN_RST)
  ) u_sync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .pin_i    (pins_raw),
    .pin_f    (pins_f)
  );

  wire scl_f  = pins_f[PIN_SCL];
  wire sda_f  = pins_f[PIN_SDA];
  wire lock_w = pins_f[PIN_LOCK];
  // Pad pull-down makes a floating pin read low: writable
  wire wp_w   = pins_f[PIN_WP];

  wire scl_rise = scl_f & ~scl_prev_ff;
  wire scl_fall = ~scl_f & scl_prev_ff;
  wire scl_hi   = scl_f & scl_prev_ff;
  wire start_w  = scl_hi & sda_prev_ff & ~sda_f;
  wire stop_w   = scl_hi & ~sda_prev_ff & sda_f;

  // Link word is stable from the rise it was caught on to the next
  // rise, so the filtered SCL edge qualifies it safely
  wire rise_last  = scl_rise & (bit_cnt_ff == BIT_PRE);
  wire ack_rise   = scl_rise & (bit_cnt_ff == BIT_LAST);
  wire fall_ack   = scl_fall & (bit_cnt_ff == BIT_LAST);
  wire fall_end   = scl_fall & (bit_cnt_ff == BIT_ACK);
  wire fall_data  = scl_fall & (bit_cnt_ff != BIT_RST)
                  & (bit_cnt_ff < BIT_LAST);

  wire [2:0] strap_code = {pins_f[PIN_E2], ~pins_f[PIN_E1N],
                           pins_f[PIN_E0]};
  wire chip_match = link_shift_ff[CHIP_MSB:CHIP_LSB] == strap_code;
  wire type_match = link_shift_ff[TYPE_BIT] == TYPE_ID;
  wire sel_match  = chip_match & type_match;
  wire sel_read   = link_shift_ff[RW_BIT];
  wire prog_arm   = (state_ff == ST_WDATA) & have_data_ff
                  & (bit_cnt_ff == BIT_STOP_SLOT);

  always_comb
  begin
    nxt_state   = state_ff;
    nxt_cnt     = bit_cnt_ff;
    nxt_oe      = sda_oe_ff;
    nxt_addr    = addr_ff;
    nxt_tx      = tx_ff;
    nxt_ack     = ack_pend_ff;
    nxt_txa     = tx_active_ff;
    nxt_wp      = wp_cmd_ff;
    nxt_have    = have_data_ff;
    nxt_wr_data = wr_data_ff;
    nxt_wr_stb  = 1'b0;
    nxt_prog    = 1'b0;
    if (lock_w)
    begin
      nxt_state = ST_IDLE;
      nxt_cnt   = BIT_RST;
      nxt_oe    = 1'b0;
      nxt_addr  = ADDR_RST;
      nxt_ack   = 1'b0;
      nxt_txa   = 1'b0;
      nxt_have  = 1'b0;
    end
    else if (state_ff == ST_BUSY)
    begin
      // Polling select codes get no ack while programming
      if (prog_done)
        nxt_state = ST_IDLE;
    end
    else if (start_w)
    begin
      nxt_state = ST_DEVSEL;
      nxt_cnt   = BIT_RST;
      nxt_oe    = 1'b0;
      nxt_ack   = 1'b0;
      nxt_txa   = 1'b0;
      nxt_have  = 1'b0;
      nxt_wp    = wp_w;
    end
    else if (stop_w)
    begin
      nxt_oe  = 1'b0;
      nxt_txa = 1'b0;
      if (prog_arm)
      begin
        nxt_state = ST_BUSY;
        nxt_prog  = 1'b1;
      end
      else
        nxt_state = ST_IDLE;
    end
    else if (state_ff != ST_IDLE)
    begin
      if (scl_rise)
        nxt_cnt = bit_cnt_ff + 4'h1;
      if (fall_end)
        nxt_cnt = BIT_RST;
      // Protect level counts from Start to end of address byte
      if (state_ff == ST_DEVSEL || state_ff == ST_ADDR)
        nxt_wp = wp_cmd_ff | wp_w;
      if (rise_last)
      begin
        case (state_ff)
          ST_DEVSEL:
          begin
            if (sel_match)
            begin
              nxt_ack = 1'b1;
              nxt_addr[ADDR_W-1:ADDR_W-3] =
                link_shift_ff[UPPER_MSB:UPPER_LSB];
              nxt_state = sel_read ? ST_RDATA : ST_ADDR;
            end
            else
            begin
              nxt_ack   = 1'b0;
              nxt_state = ST_IDLE;
            end
          end
          ST_ADDR:
          begin
            nxt_ack       = 1'b1;
            nxt_addr[7:0] = link_shift_ff;
            nxt_state     = ST_WDATA;
          end
          ST_WDATA:
          begin
            nxt_ack = ~wp_cmd_ff;
            if (!wp_cmd_ff)
            begin
              nxt_wr_stb  = 1'b1;
              nxt_wr_data = link_shift_ff;
              nxt_have    = 1'b1;
            end
          end
          default:
            nxt_ack = 1'b0;
        endcase
      end
      if (ack_rise && state_ff == ST_RDATA && tx_active_ff)
      begin
        // Counter rolls over through the whole array
        nxt_addr = addr_ff + 11'h001;
        if (sda_f)
        begin
          nxt_state = ST_IDLE;
          nxt_txa   = 1'b0;
        end
      end
      if (fall_ack)
      begin
        nxt_oe = ack_pend_ff;
        if (state_ff == ST_WDATA && ack_pend_ff && have_data_ff)
          nxt_addr[PAGE_W-1:0] = addr_ff[PAGE_W-1:0] + 4'h1;
      end
      if (fall_end)
      begin
        nxt_oe  = 1'b0;
        nxt_ack = 1'b0;
        if (state_ff == ST_RDATA)
        begin
          nxt_oe  = ~rd_data[7];
          nxt_tx  = {rd_data[6:0], 1'b0};
          nxt_txa = 1'b1;
        end
      end
      if (fall_data && tx_active_ff)
      begin
        nxt_oe = ~tx_ff[7];
        nxt_tx = {tx_ff[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_ff     <= ST_IDLE;
      bit_cnt_ff   <= BIT_RST;
      sda_oe_ff    <= 1'b0;
      addr_ff      <= ADDR_RST;
      tx_ff        <= BYTE_RST;
      ack_pend_ff  <= 1'b0;
      tx_active_ff <= 1'b0;
      wp_cmd_ff    <= 1'b0;
      have_data_ff <= 1'b0;
    end
    else
    begin
      state_ff     <= nxt_state;
      bit_cnt_ff   <= nxt_cnt;
      sda_oe_ff    <= nxt_oe;
      addr_ff      <= nxt_addr;
      tx_ff        <= nxt_tx;
      ack_pend_ff  <= nxt_ack;
      tx_active_ff <= nxt_txa;
      wp_cmd_ff    <= nxt_wp;
      have_data_ff <= nxt_have;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_data_ff  <= BYTE_RST;
      wr_stb_ff   <= 1'b0;
      prog_ff     <= 1'b0;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end
    else
    begin
      wr_data_ff  <= nxt_wr_data;
      wr_stb_ff   <= nxt_wr_stb;
      prog_ff     <= nxt_prog;
      scl_prev_ff <= scl_f;
      sda_prev_ff <= sda_f;
    end
  end

  // Open drain: the pad only ever pulls low
  assign sda_o   = 1'b0;
  assign sda_oe  = sda_oe_ff;
  assign mem_req = {addr_ff, wr_data_ff, wr_stb_ff, prog_ff};

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  a_lock_quiet: assert property (
    lock_w |=> !sda_oe_ff && state_ff == ST_IDLE && addr_ff == ADDR_RST)
    else $error("lock-out left bus driven or state active");

  a_idle_released: assert property (
    state_ff == ST_IDLE |-> !sda_oe_ff)
    else $error("SDA pulled low in standby");

  a_busy_released: assert property (
    state_ff == ST_BUSY |-> !sda_oe_ff)
    else $error("SDA pulled low while programming");

  a_prog_on_stop: assert property (
    prog_ff |-> $past(stop_w) && $past(state_ff) == ST_WDATA
      && $past(bit_cnt_ff) == BIT_STOP_SLOT && state_ff == ST_BUSY)
    else $error("programming started outside tenth slot stop");

  a_start_resync: assert property (
    start_w && !lock_w && state_ff != ST_BUSY
      |=> state_ff == ST_DEVSEL && bit_cnt_ff == BIT_RST)
    else $error("start not taken");

  a_wp_refuse: assert property (
    wr_stb_ff |-> !$past(wp_cmd_ff) && ack_pend_ff)
    else $error("write accepted under write protect");

  a_page_upper: assert property (
    state_ff == ST_WDATA && $past(state_ff) == ST_WDATA
      |-> $stable(addr_ff[ADDR_W-1:PAGE_W]))
    else $error("page write moved upper address bits");

  a_ack_slot: assert property (
    $rose(sda_oe_ff) && !tx_active_ff |-> bit_cnt_ff == BIT_LAST)
    else $error("acknowledge driven outside ninth bit");

  a_noack_idle: assert property (
    state_ff == ST_RDATA && tx_active_ff && ack_rise && sda_f
      && !lock_w && !start_w && !stop_w
      |=> state_ff == ST_IDLE ##1 !sda_oe_ff)
    else $error("read continued after noack");

  c_prog: cover property (prog_ff);
  c_read_noack: cover property (
    state_ff == ST_RDATA && tx_active_ff && ack_rise && sda_f);
  c_wp_refuse: cover property (
    state_ff == ST_WDATA && rise_last && wp_cmd_ff);
  c_nomatch: cover property (
    state_ff == ST_DEVSEL && rise_last && !sel_match);
endmodule : sefe_front_end

// file: testbench/sefe_bus_master.sv
// Two-wire bus master model: drives SCL, pulls SDA low, samples the wire
module sefe_bus_master (
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda_in
);
  timeunit 1ns;
  timeprecision 1ns;

  // Clock stands high between frames
  initial
  begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  // Long low phase covers the slave's synchroniser delay
  task automatic put_bit(input logic b);
    #20 sda_pull = ~b;
    #140 scl = 1'b1;
    #40 scl = 1'b0;
  endtask : put_bit

  task automatic start();
    #20 sda_pull = 1'b0;
    #140 scl = 1'b1;
    #60 sda_pull = 1'b1;
    #60 scl = 1'b0;
  endtask : start

  task automatic stop();
    #20 sda_pull = 1'b1;
    #140 scl = 1'b1;
    #60 sda_pull = 1'b0;
    #60;
  endtask : stop

  task automatic put_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--)
      put_bit(d[i]);
    #20 sda_pull = 1'b0;
    #140 scl = 1'b1;
    ack = ~sda_in;
    #40 scl = 1'b0;
  endtask : put_byte

  task automatic get_byte(input logic ack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--)
    begin
      #20 sda_pull = 1'b0;
      #140 scl = 1'b1;
      d[i] = sda_in;
      #40 scl = 1'b0;
    end
    put_bit(~ack);
  endtask : get_byte
endmodule : sefe_bus_master

// file: testbench/tb_top.sv
// Self-checking bench for the serial EEPROM slave front end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import sefe_pkg::*;

  // Arbitrary type identifier value
  localparam logic       TYPE_V = 1'h0;
  localparam logic [2:0] CHIP_V = 3'h6;

  logic          core_clk;
  logic          resetn;
  logic          scl;
  logic          m_pull;
  logic          sda_wire;
  logic          sda_o;
  logic          sda_oe;
  logic          chip_sel_pin0;
  logic          chip_sel_pin1_inverted;
  logic          chip_sel_pin2;
  logic          write_protect_input;
  logic          supply_lockout_reset;
  logic [7:0]    rd_data = 8'h00;
  logic          prog_done = 1'b0;
  sefe_mem_req_t mem_req;
  logic [18:0]   wr_q[$];
  int            prog_cnt = 0;
  int            n_prog = 0;
  int            n_mismatch = 0;
  int            tests_run = 0;

  // Pull-up: wire is low while either side pulls
  assign sda_wire = ~(m_pull | sda_oe);

  sefe_bus_master m (
    .scl      (scl),
    .sda_pull (m_pull),
    .sda_in   (sda_wire)
  );

  sefe_front_end #(.TYPE_ID(TYPE_V)) DUT (
    .core_clk               (core_clk),
    .resetn                 (resetn),
    .link_scl_clk           (scl),
    .sda_i                  (sda_wire),
    .sda_o                  (sda_o),
    .sda_oe                 (sda_oe),
    .chip_sel_pin0          (chip_sel_pin0),
    .chip_sel_pin1_inverted (chip_sel_pin1_inverted),
    .chip_sel_pin2          (chip_sel_pin2),
    .write_protect_input    (write_protect_input),
    .supply_lockout_reset   (supply_lockout_reset),
    .rd_data                (rd_data),
    .prog_done              (prog_done),
    .mem_req                (mem_req)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic check(input logic [18:0] seen, input logic [18:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    if (n_mismatch == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out

  // Array model answers from the address, programming takes 300 cycles
  always @(negedge core_clk)
  begin
    rd_data   <= mem_req.addr[7:0] ^ 8'h5A;
    prog_done <= (prog_cnt == 1);
    if (mem_req.prog_start)
      prog_cnt <= 300;
    else if (prog_cnt != 0)
      prog_cnt <= prog_cnt - 1;
  end

  always @(posedge core_clk)
  begin
    if (mem_req.wr_stb === 1'b1)
      wr_q.push_back({mem_req.addr, mem_req.data});
    if (mem_req.prog_start === 1'b1)
      n_prog++;
    if (sda_oe === 1'b1)
      check(sda_o, 1'b0);
  end

  function automatic logic [7:0] sel(input logic [2:0] up, input logic rw);
    return {TYPE_V, CHIP_V, up, rw};
  endfunction : sel

  // Bus activity starts off the core clock edges
  task automatic settle(input int n);
    repeat (n) @(negedge core_clk);
    #7;
  endtask : settle

  task automatic sc_write();
    logic a;
    wr_q.delete();
    m.start();
    m.put_byte(sel(3'h1, 1'b0), a);
    check(a, 1'b1);
    m.put_byte(8'h3F, a);
    check(a, 1'b1);
    m.put_byte(8'hC3, a);
    check(a, 1'b1);
    m.put_byte(8'h3C, a);
    check(a, 1'b1);
    m.stop();
    settle(10);
    check(19'(wr_q.size()), 19'h2);
    check(wr_q[0], {11'h13F, 8'hC3});
    check(wr_q[1], {11'h130, 8'h3C});
    check(19'(n_prog), 19'h1);
    m.start();
    m.put_byte(sel(3'h1, 1'b0), a);
    m.stop();
    check(a, 1'b0);
    settle(320);
    m.start();
    m.put_byte(sel(3'h1, 1'b0), a);
    m.stop();
    check(a, 1'b1);
    settle(10);
    check(19'(n_prog), 19'h1);
  endtask : sc_write

  task automatic sc_select();
    logic a;
    for (int c = 0; c < 8; c++)
    begin
      m.start();
      m.put_byte({TYPE_V, 3'(c), 4'h0}, a);
      m.stop();
      check(a, 3'(c) == CHIP_V);
    end
    m.start();
    m.put_byte({~TYPE_V, CHIP_V, 4'h0}, a);
    m.stop();
    check(a, 1'b0);
  endtask : sc_select

  task automatic sc_protect();
    logic a;
    wr_q.delete();
    @(negedge core_clk);
    write_protect_input = 1'b1;
    settle(4);
    m.start();
    m.put_byte(sel(3'h0, 1'b0), a);
    check(a, 1'b1);
    m.put_byte(8'h20, a);
    check(a, 1'b1);
    m.put_byte(8'hAA, a);
    check(a, 1'b0);
    m.stop();
    settle(10);
    check(19'(wr_q.size()), 19'h0);
    check(19'(n_prog), 19'h1);
    @(negedge core_clk);
    write_protect_input = 1'b0;
    settle(4);
  endtask : sc_protect

  // Stops mid-byte and before any data must not program
  task automatic sc_stop_slot();
    logic a;
    wr_q.delete();
    m.start();
    m.put_byte(sel(3'h4, 1'b0), a);
    m.put_byte(8'h40, a);
    m.put_byte(8'h11, a);
    m.put_bit(1'b1);
    m.put_bit(1'b0);
    m.put_bit(1'b1);
    m.stop();
    m.start();
    m.put_byte(sel(3'h4, 1'b0), a);
    m.put_byte(8'h41, a);
    m.stop();
    settle(10);
    check(19'(wr_q.size()), 19'h1);
    check(wr_q[0], {11'h440, 8'h11});
    check(19'(n_prog), 19'h1);
  endtask : sc_stop_slot

  task automatic sc_read();
    logic       a;
    logic [7:0] d;
    m.start();
    m.put_byte(sel(3'h2, 1'b0), a);
    m.put_byte(8'hFF, a);
    m.start();
    m.put_byte(sel(3'h2, 1'b1), a);
    check(a, 1'b1);
    m.get_byte(1'b1, d);
    check(d, 8'hA5);
    m.get_byte(1'b0, d);
    check(d, 8'h5A);
    m.stop();
    settle(10);
    check(sda_oe, 1'b0);
    m.start();
    m.put_byte(sel(3'h3, 1'b1), a);
    m.get_byte(1'b0, d);
    // Next byte would start with a driven zero if the noack were missed
    settle(8);
    check(sda_oe, 1'b0);
    m.stop();
    check(d, 8'h5B);
  endtask : sc_read

  task automatic sc_lockout();
    logic       a;
    logic [7:0] d;
    @(negedge core_clk);
    supply_lockout_reset = 1'b1;
    settle(8);
    m.start();
    m.put_byte(sel(3'h0, 1'b0), a);
    m.stop();
    check(a, 1'b0);
    @(negedge core_clk);
    supply_lockout_reset = 1'b0;
    settle(8);
    m.start();
    m.put_byte(sel(3'h0, 1'b1), a);
    m.get_byte(1'b0, d);
    m.stop();
    check(a, 1'b1);
    check(d, 8'h5A);
  endtask : sc_lockout

  initial
  begin
    resetn                 = 1'b0;
    chip_sel_pin0          = 1'b0;
    chip_sel_pin1_inverted = 1'b0;
    chip_sel_pin2          = 1'b1;
    write_protect_input    = 1'b0;
    supply_lockout_reset   = 1'b0;
    repeat (3) @(negedge core_clk);
    resetn = 1'b1;
    settle(10);
    sc_write();
    sc_select();
    sc_protect();
    sc_stop_slot();
    sc_read();
    sc_lockout();
    close_out();
  end

  // Whole sequence needs about 80 us
  initial
  begin
    #400000;
    n_mismatch++;
    close_out();
  end
endmodule : tb_top
